// ===== dcwd_defs.svh
/*
 * Constants of the drive control word decoder: bit positions of the
 * primary control word, telegram type codes, reset values and widths.
 * Assumes it is included by its bare name wherever the names are used.
 */
`ifndef DCWD_DEFS_SVH
`define DCWD_DEFS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define DCWD_WORD_WIDTH 16
`define DCWD_TEL_WIDTH 10
`define DCWD_ACK_SOURCES 3
`define DCWD_PIN_COUNT 4

// ----------------------------------------------------------------------
// bit positions in the primary control word
// ----------------------------------------------------------------------
`define DCWD_BIT_ON 0
`define DCWD_BIT_COAST 1
`define DCWD_BIT_QUICK 2
`define DCWD_BIT_OPERATE 3
`define DCWD_BIT_RFG_ENABLE 4
`define DCWD_BIT_RFG_START 5
`define DCWD_BIT_SETPOINT 6
`define DCWD_BIT_ACK 7
`define DCWD_BIT_MASTER 10
`define DCWD_BIT_POT_RAISE 13
`define DCWD_BIT_POT_LOWER 14
`define DCWD_BIT_CDS0 15

// ----------------------------------------------------------------------
// positions of the synchronised pins in the pin vector
// ----------------------------------------------------------------------
`define DCWD_PIN_COAST_B 0
`define DCWD_PIN_QUICK_B 1
`define DCWD_PIN_ACK_TWO 2
`define DCWD_PIN_ACK_THREE 3

// ----------------------------------------------------------------------
// telegram types that give bits 13 and 14 their meaning
// ----------------------------------------------------------------------
`define DCWD_TEL_STANDARD 10'h001
`define DCWD_TEL_PROCESS 10'h160

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DCWD_WORD_RESET 16'h0000
`define DCWD_SETPOINT_ZERO 16'h0000
`define DCWD_ACK_PREV_RESET 1'b1

`endif

// ===== dcwd_pkg.sv
/*
 * Types of the drive control word decoder: the sequencer state.
 * Assumes dcwd_defs.svh holds the numeric constants.
 */
package dcwd_pkg;

    // ------------------------------------------------------------------
    // one-hot sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        st_off = 5'h01,
        st_ready = 5'h02,
        st_run = 5'h04,
        st_ramp_stop = 5'h08,
        st_quick_stop = 5'h10
    } dcwd_state_t;

endpackage

// ===== dcwd_ack_if.sv
/*
 * Carrier between the decoder and its fault acknowledge unit: the
 * levels of the acknowledge sources and the resulting pulse.
 * Assumes all signals belong to the one drive control clock.
 */
`timescale 1ns/100ps
interface dcwd_ack_if #(
    parameter int SOURCES = 3
);
    logic [SOURCES-1:0] level;
    logic ack;

    // decoder drives the levels and takes the pulse
    modport decoder (
        output level,
        input ack
    );

    // acknowledge unit reads the levels and makes the pulse
    modport unit (
        input level,
        output ack
    );
endinterface

// ===== dcwd_fault_ack.sv
/*
 * Fault acknowledge unit: one rising edge detector per source, the
 * detected edges merged into a one-cycle pulse.
 * Assumes every level is already in the clock domain.
 */
`timescale 1ns/100ps
module dcwd_fault_ack #(
    parameter int SOURCES = 3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_enable,
    dcwd_ack_if.unit ack_bus
);
    `include "dcwd_defs.svh"

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    logic [SOURCES-1:0] prev;
    logic [SOURCES-1:0] rise;
    logic ack_pulse;

    genvar i;
    generate
        for (i = 0; i < SOURCES; i = i + 1) begin : g_src
            // remember the last level; reset high so no edge at start
            always_ff @(posedge clock) begin
                if (rst) begin
                    prev[i] <= `DCWD_ACK_PREV_RESET;
                end else if (clock_enable) begin
                    prev[i] <= ack_bus.level[i];
                end
            end
            // each source looks only at its own edge
            assign rise[i] = ack_bus.level[i] & ~prev[i];
        end
    endgenerate

    // ------------------------------------------------------------------
    // merged pulse, a steady level gives nothing
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_pulse <= 1'b0;
        end else if (clock_enable) begin
            ack_pulse <= |rise;
        end
    end

    assign ack_bus.ack = ack_pulse;
endmodule

// ===== dcwd_decoder.sv
/*
 * Drive control word decoder: takes the primary control word and the
 * speed setpoint word from the fieldbus receive logic, decodes stop
 * commands, a small switch-on sequencer, ramp-function generator
 * controls, fault acknowledge, motorized potentiometer and command set.
 * Assumes word_valid is a one-cycle strobe from same-clock logic and
 * the separately wired sources arrive asynchronously on pins.
 */
`timescale 1ns/100ps
`include "dcwd_defs.svh"
module dcwd_decoder import dcwd_pkg::*; #(
    parameter int WORD_WIDTH = `DCWD_WORD_WIDTH,
    parameter int TEL_WIDTH = `DCWD_TEL_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_enable,
    input wire logic word_valid,
    input wire logic [WORD_WIDTH-1:0] process_data_word,
    input wire logic [WORD_WIDTH-1:0] setpoint_data_word,
    input wire logic [TEL_WIDTH-1:0] telegram_type_select,
    input wire logic coast_stop_source_b,
    input wire logic quick_stop_source_b,
    input wire logic fault_ack_source_two,
    input wire logic fault_ack_source_three,
    input wire logic speed_at_zero,
    output logic ramp_stop_command,
    output logic coast_stop_command,
    output logic quick_stop_command,
    output logic switch_on_pulse,
    output logic pulse_enable,
    output logic line_contactor_close,
    output logic ready_for_operation,
    output logic quick_ramp_select,
    output logic stop_ramp_active,
    output logic rfg_zero_output,
    output logic rfg_hold_output,
    output logic [WORD_WIDTH-1:0] rfg_input_setpoint,
    output logic fault_ack,
    output logic master_control,
    output logic potentiometer_raise,
    output logic potentiometer_lower,
    output logic potentiometer_hold,
    output logic command_set_select
);

    // ------------------------------------------------------------------
    // pot bit decoding, valid only in the two standard telegrams
    // ------------------------------------------------------------------
    function automatic logic pot_bits_valid(
        input logic [TEL_WIDTH-1:0] tel
    );
        pot_bits_valid = (tel == `DCWD_TEL_STANDARD) ||
                         (tel == `DCWD_TEL_PROCESS);
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [`DCWD_PIN_COUNT-1:0] pin_raw;
    logic [`DCWD_PIN_COUNT-1:0] pin_meta;
    logic [`DCWD_PIN_COUNT-1:0] pin_sync;
    logic [WORD_WIDTH-1:0] cw;
    logic [WORD_WIDTH-1:0] setpoint_word;
    logic on_prev;
    logic on_rise;
    logic coast_active;
    logic quick_active;
    logic pot_valid;
    dcwd_state_t state;
    dcwd_state_t next_state;

    dcwd_ack_if #(.SOURCES(`DCWD_ACK_SOURCES)) ack_bus ();

    // ------------------------------------------------------------------
    // two-stage synchronisers for the separately wired pins
    // ------------------------------------------------------------------
    assign pin_raw[`DCWD_PIN_COAST_B] = coast_stop_source_b;
    assign pin_raw[`DCWD_PIN_QUICK_B] = quick_stop_source_b;
    assign pin_raw[`DCWD_PIN_ACK_TWO] = fault_ack_source_two;
    assign pin_raw[`DCWD_PIN_ACK_THREE] = fault_ack_source_three;

    genvar p;
    generate
        for (p = 0; p < `DCWD_PIN_COUNT; p = p + 1) begin : g_sync
            // first stage feeds only the second
            always_ff @(posedge clock) begin
                if (rst) begin
                    pin_meta[p] <= 1'b0;
                    pin_sync[p] <= 1'b0;
                end else if (clock_enable) begin
                    pin_meta[p] <= pin_raw[p];
                    pin_sync[p] <= pin_meta[p];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // word capture
    // ------------------------------------------------------------------
    // the first receive word is the control word; bit 10 is always
    // tracked, the rest only counts while the master has control
    always_ff @(posedge clock) begin
        if (rst) begin
            cw <= `DCWD_WORD_RESET;
            setpoint_word <= `DCWD_SETPOINT_ZERO;
        end else if (clock_enable && word_valid) begin
            if (process_data_word[`DCWD_BIT_MASTER]) begin
                cw <= process_data_word;
                setpoint_word <= setpoint_data_word;
            end
        end
    end

    // master control flag, follows bit 10 of every received word
    always_ff @(posedge clock) begin
        if (rst) begin
            master_control <= 1'b0;
        end else if (clock_enable && word_valid) begin
            // master is trusted to raise it only once we are ready
            master_control <= process_data_word[`DCWD_BIT_MASTER];
        end
    end

    // ------------------------------------------------------------------
    // stop signals from their paired sources
    // ------------------------------------------------------------------
    // reserved bits 8, 9, 11 and 12 are never looked at
    assign coast_active = ~(cw[`DCWD_BIT_COAST] &
                            pin_sync[`DCWD_PIN_COAST_B]);
    assign quick_active = ~(cw[`DCWD_BIT_QUICK] &
                            pin_sync[`DCWD_PIN_QUICK_B]);
    assign on_rise = cw[`DCWD_BIT_ON] & ~on_prev;
    assign pot_valid = pot_bits_valid(telegram_type_select);

    // previous switch-on level for the edge; reset high avoids a
    // switch-on right after reset
    always_ff @(posedge clock) begin
        if (rst) begin
            on_prev <= 1'b1;
        end else if (clock_enable) begin
            on_prev <= cw[`DCWD_BIT_ON];
        end
    end

    // ------------------------------------------------------------------
    // switch-on sequencer
    // ------------------------------------------------------------------
    // coast stop wins everywhere, quick stop next, then ramp stop
    always_comb begin
        next_state = state;
        case (state)
            st_off: begin
                if (on_rise && !coast_active && !quick_active) begin
                    next_state = st_ready;
                end
            end
            st_ready: begin
                if (coast_active || quick_active ||
                    !cw[`DCWD_BIT_ON]) begin
                    next_state = st_off;
                end else if (cw[`DCWD_BIT_OPERATE]) begin
                    next_state = st_run;
                end
            end
            st_run: begin
                if (coast_active) begin
                    next_state = st_off;
                end else if (quick_active) begin
                    next_state = st_quick_stop;
                end else if (!cw[`DCWD_BIT_ON]) begin
                    next_state = st_ramp_stop;
                end else if (!cw[`DCWD_BIT_OPERATE]) begin
                    next_state = st_ready;
                end
            end
            st_ramp_stop: begin
                if (coast_active) begin
                    next_state = st_off;
                end else if (quick_active) begin
                    next_state = st_quick_stop;
                end else if (speed_at_zero) begin
                    next_state = st_off;
                end
            end
            st_quick_stop: begin
                if (coast_active || speed_at_zero) begin
                    next_state = st_off;
                end
            end
            default: begin
                next_state = st_off;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= st_off;
        end else if (clock_enable) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // power stage outputs
    // ------------------------------------------------------------------
    // pulses run while operating and while ramping down to zero
    always_ff @(posedge clock) begin
        if (rst) begin
            pulse_enable <= 1'b0;
            line_contactor_close <= 1'b0;
            ready_for_operation <= 1'b0;
        end else if (clock_enable) begin
            pulse_enable <= (next_state == st_run) ||
                            (next_state == st_ramp_stop) ||
                            (next_state == st_quick_stop);
            line_contactor_close <= (next_state != st_off);
            ready_for_operation <= (next_state != st_off);
        end
    end

    // ramp selection during a stop
    always_ff @(posedge clock) begin
        if (rst) begin
            quick_ramp_select <= 1'b0;
            stop_ramp_active <= 1'b0;
        end else if (clock_enable) begin
            quick_ramp_select <= (next_state == st_quick_stop);
            stop_ramp_active <= (next_state == st_ramp_stop) ||
                                (next_state == st_quick_stop);
        end
    end

    // ------------------------------------------------------------------
    // decoded command levels
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            ramp_stop_command <= 1'b1;
            coast_stop_command <= 1'b1;
            quick_stop_command <= 1'b1;
            switch_on_pulse <= 1'b0;
        end else if (clock_enable) begin
            ramp_stop_command <= ~cw[`DCWD_BIT_ON];
            coast_stop_command <= coast_active;
            quick_stop_command <= quick_active;
            switch_on_pulse <= on_rise;
        end
    end

    // ------------------------------------------------------------------
    // ramp-function generator controls
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            rfg_zero_output <= 1'b1;
            rfg_hold_output <= 1'b1;
            rfg_input_setpoint <= `DCWD_SETPOINT_ZERO;
        end else if (clock_enable) begin
            rfg_zero_output <= ~cw[`DCWD_BIT_RFG_ENABLE];
            rfg_hold_output <= ~cw[`DCWD_BIT_RFG_START];
            if (cw[`DCWD_BIT_SETPOINT]) begin
                rfg_input_setpoint <= setpoint_word;
            end else begin
                rfg_input_setpoint <= `DCWD_SETPOINT_ZERO;
            end
        end
    end

    // ------------------------------------------------------------------
    // motorized potentiometer and command set
    // ------------------------------------------------------------------
    // equal raise and lower, or a telegram without them, holds
    always_ff @(posedge clock) begin
        if (rst) begin
            potentiometer_raise <= 1'b0;
            potentiometer_lower <= 1'b0;
            potentiometer_hold <= 1'b1;
        end else if (clock_enable) begin
            potentiometer_raise <= pot_valid &
                                   cw[`DCWD_BIT_POT_RAISE] &
                                   ~cw[`DCWD_BIT_POT_LOWER];
            potentiometer_lower <= pot_valid &
                                   cw[`DCWD_BIT_POT_LOWER] &
                                   ~cw[`DCWD_BIT_POT_RAISE];
            potentiometer_hold <= ~pot_valid |
                                  (cw[`DCWD_BIT_POT_RAISE] ==
                                   cw[`DCWD_BIT_POT_LOWER]);
        end
    end

    // command set bit 0
    always_ff @(posedge clock) begin
        if (rst) begin
            command_set_select <= 1'b0;
        end else if (clock_enable) begin
            command_set_select <= cw[`DCWD_BIT_CDS0];
        end
    end

    // ------------------------------------------------------------------
    // fault acknowledge from the word and two pins
    // ------------------------------------------------------------------
    assign ack_bus.level[0] = cw[`DCWD_BIT_ACK];
    assign ack_bus.level[1] = pin_sync[`DCWD_PIN_ACK_TWO];
    assign ack_bus.level[2] = pin_sync[`DCWD_PIN_ACK_THREE];

    dcwd_fault_ack #(
        .SOURCES(`DCWD_ACK_SOURCES)
    ) u_fault_ack (
        .clock(clock),
        .rst(rst),
        .clock_enable(clock_enable),
        .ack_bus(ack_bus)
    );

    // pulse comes from the unit's own flip-flop
    assign fault_ack = ack_bus.ack;

endmodule

// ===== dcwd_master.sv
/*
 * Fieldbus master model: one two-word telegram per call.
 * Assumes the caller may block; words change at the falling edge.
 */
`timescale 1ns/100ps
module dcwd_master (
    input wire logic clock,
    output logic word_valid,
    output logic [15:0] process_data_word,
    output logic [15:0] setpoint_data_word
);
    // ----------
    // idle bus and the telegram task
    // ----------
    initial begin
        word_valid = 1'b0;
        process_data_word = 16'h0000;
        setpoint_data_word = 16'h0000;
    end

    // released words show the inverse so stale data cannot pass
    task automatic send(input logic [15:0] cw, input logic [15:0] sp);
        @(negedge clock);
        word_valid = 1'b1;
        process_data_word = cw & 16'hE4FF;
        setpoint_data_word = sp;
        @(negedge clock);
        word_valid = 1'b0;
        process_data_word = ~process_data_word;
        setpoint_data_word = ~setpoint_data_word;
    endtask
endmodule

// ===== dcwd_decoder_asserts.sv
/*
 * Checker of the control word decoder, watching its ports only.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module dcwd_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_enable,
    input wire logic word_valid,
    input wire logic [15:0] process_data_word,
    input wire logic [15:0] setpoint_data_word,
    input wire logic [9:0] telegram_type_select,
    input wire logic coast_stop_source_b,
    input wire logic quick_stop_source_b,
    input wire logic coast_stop_command,
    input wire logic quick_stop_command,
    input wire logic switch_on_pulse,
    input wire logic pulse_enable,
    input wire logic line_contactor_close,
    input wire logic rfg_zero_output,
    input wire logic rfg_hold_output,
    input wire logic [15:0] rfg_input_setpoint,
    input wire logic fault_ack,
    input wire logic master_control,
    input wire logic potentiometer_raise,
    input wire logic potentiometer_lower,
    input wire logic potentiometer_hold,
    input wire logic command_set_select
);
    // ----------
    // shadow of the last accepted word, edge bits start high
    // ----------
    logic [15:0] pdw;
    logic take;
    logic [15:0] shadow;
    assign pdw = process_data_word;
    assign take = clock_enable && word_valid && pdw[10];
    always_ff @(posedge clock) begin
        if (rst) begin
            shadow <= 16'h0081;
        end else if (take) begin
            shadow <= pdw;
        end
    end

    // ----------
    // properties
    // ----------
    default clocking dclk @(posedge clock); endclocking
    default disable iff (rst);
    // accepted word, then one enabled edge to register the outputs
    sequence s_take(b);
        take && b ##1 clock_enable;
    endsequence

    property p_master; clock_enable && word_valid |=>
        master_control == $past(pdw[10]); endproperty
    a_master: assert property (p_master) else $error("master bit");
    property p_ign; !word_valid ##1 clock_enable && word_valid && !pdw[10]
        |=> $stable(rfg_input_setpoint) && $stable(command_set_select);
    endproperty
    a_ign: assert property (p_ign) else $error("word not ignored");
    property p_rfg; s_take(1'b1) |=>
        {rfg_hold_output, rfg_zero_output} == ~$past(pdw[5:4], 2); endproperty
    a_rfg: assert property (p_rfg) else $error("ramp controls");
    property p_setp; s_take(1'b1) |=> rfg_input_setpoint ==
        ($past(pdw[6], 2) ? $past(setpoint_data_word, 2) : 16'h0000);
    endproperty
    a_setp: assert property (p_setp) else $error("setpoint gate");
    property p_ack; s_take(pdw[7] && !shadow[7]) |=> fault_ack; endproperty
    a_ack: assert property (p_ack) else $error("no acknowledge");
    property p_on; s_take(pdw[0] && !shadow[0]) |=> switch_on_pulse;
    endproperty
    a_on: assert property (p_on) else $error("no switch on");
    property p_raise; s_take(telegram_type_select == 10'h001 &&
        pdw[14:13] == 2'b01) |=> potentiometer_raise; endproperty
    a_raise: assert property (p_raise) else $error("pot raise");
    property p_hold; s_take(pdw[14] == pdw[13]) |=> potentiometer_hold &&
        !potentiometer_raise && !potentiometer_lower; endproperty
    a_hold: assert property (p_hold) else $error("pot hold");
    property p_cds; s_take(1'b1) |=>
        command_set_select == $past(pdw[15], 2); endproperty
    a_cds: assert property (p_cds) else $error("command set");
    property p_coast; (clock_enable && !coast_stop_source_b) [*4] |->
        coast_stop_command; endproperty
    a_coast: assert property (p_coast) else $error("coast source");
    property p_quick; (clock_enable && !quick_stop_source_b) [*4] |->
        quick_stop_command; endproperty
    a_quick: assert property (p_quick) else $error("quick source");
    property p_off; (clock_enable && coast_stop_command) [*2] |->
        !pulse_enable && !line_contactor_close; endproperty
    a_off: assert property (p_off) else $error("coast not off");
endmodule

bind dcwd_decoder dcwd_chk i_chk (.*);

// ===== tb.sv
/*
 * Testbench of the control word decoder: telegrams, pins and compares.
 * Assumes the design, master model and checker are compiled with it.
 */
`timescale 1ns/100ps
module tb;
    // ----------
    // signals named after the decoder ports
    // ----------
    logic clock = 1'b0;
    logic rst, clock_enable, word_valid, speed_at_zero;
    logic [15:0] process_data_word, setpoint_data_word, rfg_input_setpoint;
    logic [9:0] telegram_type_select;
    logic coast_stop_source_b, quick_stop_source_b;
    logic fault_ack_source_two, fault_ack_source_three;
    logic ramp_stop_command, coast_stop_command, quick_stop_command;
    logic switch_on_pulse, pulse_enable, line_contactor_close;
    logic ready_for_operation, quick_ramp_select, stop_ramp_active;
    logic rfg_zero_output, rfg_hold_output, fault_ack, master_control;
    logic potentiometer_raise, potentiometer_lower, potentiometer_hold;
    logic command_set_select;
    logic [2:0] pot;
    int bad_count = 0;
    int num_checks = 0;
    int acks = 0;
    int n0, i;
    logic [9:0] tt [5] = '{10'h001, 10'h160, 10'h001, 10'h014, 10'h160};
    logic [1:0] bb [5] = '{2'b01, 2'b10, 2'b11, 2'b01, 2'b00};
    logic [2:0] ee [5] = '{3'b100, 3'b010, 3'b001, 3'b001, 3'b001};

    always #20 clock = ~clock;
    assign pot = {potentiometer_raise, potentiometer_lower, potentiometer_hold};
    // count acknowledge pulses as they stand at each edge
    always @(posedge clock) if (fault_ack === 1'b1) acks++;

    dcwd_decoder i_dut (.*);
    dcwd_master i_master (.clock, .word_valid, .process_data_word,
        .setpoint_data_word);

    // ----------
    // tasks
    // ----------
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one telegram, then wait until the sequencer has settled
    task automatic step(input logic [15:0] cw, input logic [15:0] sp);
        i_master.send(cw, sp);
        repeat (2) @(negedge clock);
    endtask
    task automatic zero_speed();
        speed_at_zero = 1'b1;
        repeat (3) @(negedge clock);
        speed_at_zero = 1'b0;
        chk("pulse_enable", 0, pulse_enable);
        chk("ready_for_operation", 0, ready_for_operation);
    endtask
    task automatic done(input string n);
        $display("test %s complete", n);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------
    // watchdog and test sequence
    // ----------
    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        clock_enable = 1'b1;
        speed_at_zero = 1'b0;
        telegram_type_select = 10'h001;
        coast_stop_source_b = 1'b1;
        quick_stop_source_b = 1'b1;
        fault_ack_source_two = 1'b0;
        fault_ack_source_three = 1'b0;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        chk("coast_stop_command", 1, coast_stop_command);
        chk("ramp_stop_command", 1, ramp_stop_command);
        step(16'h0406, 16'h0000);
        step(16'h047F, 16'h1234);
        chk("ready_for_operation", 1, ready_for_operation);
        chk("pulse_enable", 1, pulse_enable);
        chk("rfg_input_setpoint", 16'h1234, rfg_input_setpoint);
        step(16'h0477, 16'h1234);
        chk("pulse_enable", 0, pulse_enable);
        chk("ready_for_operation", 1, ready_for_operation);
        step(16'h040F, 16'h1234);
        chk("rfg_zero_output", 1, rfg_zero_output);
        chk("rfg_hold_output", 1, rfg_hold_output);
        chk("rfg_input_setpoint", 0, rfg_input_setpoint);
        done("switch_on_and_ramp");
        step(16'h0000, 16'h5555);
        chk("master_control", 0, master_control);
        chk("ramp_stop_command", 0, ramp_stop_command);
        clock_enable = 1'b0;
        step(16'h047F, 16'h5555);
        clock_enable = 1'b1;
        chk("master_control", 0, master_control);
        done("master_control");
        n0 = acks;
        step(16'h04FF, 16'h0100);
        step(16'h04FF, 16'h0100);
        chk("fault_ack count", 1, acks - n0);
        n0 = acks;
        fault_ack_source_two = 1'b1;
        repeat (5) @(negedge clock);
        fault_ack_source_three = 1'b1;
        repeat (5) @(negedge clock);
        chk("fault_ack count", 2, acks - n0);
        done("fault_ack");
        for (i = 0; i < 5; i++) begin
            telegram_type_select = tt[i];
            step({1'b0, bb[i], 13'h04FF}, 16'h0000);
            chk("pot", {13'h0000, ee[i]}, {13'h0000, pot});
        end
        telegram_type_select = 10'h001;
        step(16'h84FF, 16'h0000);
        chk("command_set_select", 1, command_set_select);
        done("pot_and_command_set");
        step(16'h04FE, 16'h0000);
        chk("stop_ramp_active", 1, stop_ramp_active);
        chk("pulse_enable", 1, pulse_enable);
        zero_speed();
        step(16'h04FF, 16'h0000);
        step(16'h04FB, 16'h0000);
        chk("quick_ramp_select", 1, quick_ramp_select);
        chk("quick_stop_command", 1, quick_stop_command);
        zero_speed();
        done("stops");
        step(16'h04FA, 16'h0000);
        step(16'h04FF, 16'h0000);
        coast_stop_source_b = 1'b0;
        repeat (5) @(negedge clock);
        chk("coast_stop_command", 1, coast_stop_command);
        chk("pulse_enable", 0, pulse_enable);
        coast_stop_source_b = 1'b1;
        quick_stop_source_b = 1'b0;
        repeat (5) @(negedge clock);
        chk("quick_stop_command", 1, quick_stop_command);
        done("stop_pins");
        finish_test();
    end
endmodule
